/* pmx_map.svh */
/*
  Register offsets, field widths, reset values and control bit positions for the
  address/PWM port. Assumes a classic Wishbone slave with 32-bit data.
*/
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH

// Offsets are word indexes: the byte address on the bus is four times them
`define PMX_IDX_PULLUP 16'hffac
`define PMX_IDX_DIRECTION 16'hffb0
`define PMX_IDX_OUTPUT_DATA 16'hffb2
// Control/status registers of this block
`define PMX_IDX_CONTROL 16'hffb8
`define PMX_IDX_STATUS 16'hffb9

`define PMX_ADDR_W 18
`define PMX_PORT_W 8
`define PMX_RESET_VALUE 8'h00

// Control register fields
`define PMX_CTL_MODE_LSB 0
`define PMX_CTL_MODE_MSB 1
`define PMX_CTL_EXP_BIT 2

`endif

/* pmx_pkg.sv */
/*
  Types shared by the port block. Assumes nothing beyond the map header.
*/
package pmx_pkg;

  // Operating mode as the chip straps it
  typedef enum logic [1:0] {
    PMX_MODE_RSVD = 2'h0,
    PMX_MODE_ONE = 2'h1,
    PMX_MODE_TWO = 2'h2,
    PMX_MODE_THREE = 2'h3
  } pmx_mode_type;

  // Power state of the chip around the port
  typedef enum logic [1:0] {
    PMX_PWR_RUN = 2'h0,
    PMX_PWR_SW_STBY = 2'h1,
    PMX_PWR_HW_STBY = 2'h2
  } pmx_pwr_type;

endpackage

/* pmx_pin_slice.sv */
/*
  One pin of the port: picks the output source and enables, and the
  pull-up. Assumes all inputs are synchronous to the caller's clock.
*/
`timescale 1ns/1ps

module pmx_pin_slice (
  input wire logic mode_one_in, // Mode 1 selected
  input wire logic expansion_in, // External expansion enable
  input wire logic hw_stby_in, // Hardware standby
  input wire logic dir_in, // Direction bit
  input wire logic data_in, // Output data bit
  input wire logic addr_in, // Address bit from bus controller
  input wire logic pwm_en_in, // PWM channel enabled
  input wire logic pwm_in, // PWM channel level
  input wire logic pullup_in, // Pull-up control bit
  output logic level_out, // Pin drive level
  output logic drive_out, // Pin output enable
  output logic pullup_out // Pull-up on
);

  // Source choice: address in mode 1, else PWM wins, then address in expansion, else data
  always_comb begin
    level_out = data_in;
    drive_out = 1'b0;
    if (mode_one_in) begin
      level_out = addr_in;
      drive_out = ~hw_stby_in;
    end else if (dir_in) begin
      drive_out = ~hw_stby_in;
      if (pwm_en_in) begin
        level_out = pwm_in;
      end else if (expansion_in) begin
        level_out = addr_in;
      end else begin
        level_out = data_in;
      end
    end
  end

  // Pull-up only for inputs outside mode 1 and hardware standby
  assign pullup_out = ~mode_one_in & ~hw_stby_in & ~dir_in & pullup_in;

endmodule

/* pmx_port.sv */
/*
  Eight-bit I/O port muxed with the low address byte and eight PWM
  channels, with a classic Wishbone register slave. Assumes mode and
  power state come from the system controller, expansion from software,
  and that the PWM unit and bus controller drive their inputs.
  Pin inputs are taken as synchronous to clk_in; any resynchronising
  belongs to the pad ring. Registers sit in byte lane 0 only, and an
  access to any other index is refused with an error, so a stray
  pointer shows up on the bus instead of corrupting a register.
*/
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pmx_map.svh"

module pmx_port #(
  parameter int PORT_W = `PMX_PORT_W
) (
  input wire logic clk_in, // 100 MHz system clock
  input wire logic arst_n_in, // Asynchronous reset, active low
  input wire logic wb_cyc_in, // Wishbone cycle
  input wire logic wb_stb_in, // Wishbone strobe
  input wire logic wb_we_in, // Wishbone write enable
  input wire logic [`PMX_ADDR_W-1:0] wb_adr_in, // Wishbone byte address
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects
  input wire logic [31:0] wb_dat_in, // Wishbone write data
  output logic [31:0] wb_dat_out, // Wishbone read data
  output logic wb_ack_out, // Wishbone acknowledge
  output logic wb_err_out, // Wishbone error for unmapped address
  input wire logic [1:0] mode_in, // Operating mode straps
  input wire logic [1:0] power_state_in, // Run, software or hardware standby
  input wire logic [PORT_W-1:0] address_low_in, // Low address byte
  input wire logic [PORT_W-1:0] pwm_channel_enable_in, // PWM channel enables
  input wire logic [PORT_W-1:0] pwm_channel_outputs_in, // PWM channel levels
  input wire logic [PORT_W-1:0] pin_in, // Pin levels
  output logic [PORT_W-1:0] pin_out, // Pin drive levels
  output logic [PORT_W-1:0] pin_oe_out, // Pin output enables, high drives
  output logic [PORT_W-1:0] pullup_on_out // Pull-up enables
);

  // Software-visible registers
  logic [PORT_W-1:0] pin_direction;
  logic [PORT_W-1:0] pin_output_data;
  logic [PORT_W-1:0] pin_pullup_control;
  logic external_expansion_enable;

  // Pin-side state and next values
  logic [PORT_W-1:0] pin_sampled;
  logic [PORT_W-1:0] address_held;
  logic [PORT_W-1:0] next_level;
  logic [PORT_W-1:0] next_drive;
  logic [PORT_W-1:0] next_pullup;
  logic [PORT_W-1:0] port_read_value;
  logic [PORT_W-1:0] address_source;

  // Read path
  logic [31:0] next_rdata;
  logic next_hit;

  // Power, mode and bus decode
  logic hw_stby;
  logic sw_stby;
  logic mode_one;
  logic bus_req;
  logic [15:0] reg_index;
  logic wr_lane0;

  // Register selects and write strobes, decoded once
  logic sel_direction;
  logic sel_output_data;
  logic sel_pullup;
  logic sel_control;
  logic wr_direction;
  logic wr_output_data;
  logic wr_pullup;
  logic wr_control;

  // Straps as enums; mode 0 is reserved and acts like modes 2 and 3
  pmx_pkg::pmx_mode_type mode;
  pmx_pkg::pmx_pwr_type power;

  // Decode strap and power inputs; power code 3 counts as run, so only
  // the two standby codes change anything
  assign mode = pmx_pkg::pmx_mode_type'(mode_in);
  assign power = pmx_pkg::pmx_pwr_type'(power_state_in);
  assign hw_stby = (power == pmx_pkg::PMX_PWR_HW_STBY);
  assign sw_stby = (power == pmx_pkg::PMX_PWR_SW_STBY);
  assign mode_one = (mode == pmx_pkg::PMX_MODE_ONE);

  // Register index is the word address; request seen once, ack ends it
  // A master that holds stb past ack is taken a second time once ack has dropped
  assign reg_index = wb_adr_in[`PMX_ADDR_W-1:2];
  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
  assign wr_lane0 = bus_req & wb_we_in & wb_sel_in[0];

  // Index compare; a write with lane 0 off is answered but stores nothing
  assign sel_direction = (reg_index == `PMX_IDX_DIRECTION);
  assign sel_output_data = (reg_index == `PMX_IDX_OUTPUT_DATA);
  assign sel_pullup = (reg_index == `PMX_IDX_PULLUP);
  assign sel_control = (reg_index == `PMX_IDX_CONTROL);

  // Write strobes, one per writable register
  assign wr_direction = wr_lane0 & sel_direction;
  assign wr_output_data = wr_lane0 & sel_output_data;
  assign wr_pullup = wr_lane0 & sel_pullup;
  assign wr_control = wr_lane0 & sel_control;

  // Direction register; hardware standby clears it like reset.
  // Software standby leaves it alone, so each pin keeps its role while
  // the clocks around the port are stopped.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_direction <= `PMX_RESET_VALUE;
    end else if (hw_stby) begin
      pin_direction <= `PMX_RESET_VALUE;
    end else if (wr_direction) begin
      pin_direction <= wb_dat_in[PORT_W-1:0];
    end
  end

  // Output data register, kept through software standby.
  // A write while a pin is an input is kept and shows once the pin
  // turns to output.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_output_data <= `PMX_RESET_VALUE;
    end else if (hw_stby) begin
      pin_output_data <= `PMX_RESET_VALUE;
    end else if (wr_output_data) begin
      pin_output_data <= wb_dat_in[PORT_W-1:0];
    end
  end

  // Pull-up control register; the pull-up itself is decided per pin in
  // the slice, which forces it off in mode 1 and hardware standby
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_pullup_control <= `PMX_RESET_VALUE;
    end else if (hw_stby) begin
      pin_pullup_control <= `PMX_RESET_VALUE;
    end else if (wr_pullup) begin
      pin_pullup_control <= wb_dat_in[PORT_W-1:0];
    end
  end

  // Expansion enable lives in the control register
  // Cleared with the port registers so a hardware standby exit starts single-chip
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      external_expansion_enable <= 1'b0;
    end else if (hw_stby) begin
      external_expansion_enable <= 1'b0;
    end else if (wr_control) begin
      external_expansion_enable <= wb_dat_in[`PMX_CTL_EXP_BIT];
    end
  end

  // Pin levels sampled once so reads see a clean value.
  // A port read therefore shows the pin level one clock late, which
  // software polling a pin never notices.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_sampled <= `PMX_RESET_VALUE;
    end else begin
      pin_sampled <= pin_in;
    end
  end

  // Address capture: frozen while in software standby.
  // The copy taken at the last run edge equals what the pins show, so
  // entering standby causes no step on the address pins. Leaving it
  // lets the live byte through again on the next edge.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      address_held <= `PMX_RESET_VALUE;
    end else if (!sw_stby) begin
      address_held <= address_low_in;
    end
  end

  // During software standby the held copy drives the address pins
  // Without it the pins would follow a bus that stops mid-transition
  assign address_source = sw_stby ? address_held : address_low_in;

  // Port read merges data bits for outputs and pin levels for inputs.
  // Output bits read the register, never the pin, so a heavily loaded
  // pin cannot corrupt a read-modify-write.
  assign port_read_value = (pin_direction & pin_output_data) |
                           (~pin_direction & pin_sampled);

  // Per-pin output selection
  // Each slice is purely combinational; the flip-flops below register
  // all eight results together so the pins change on one edge.
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      pmx_pin_slice u_slice (
        .mode_one_in(mode_one),
        .expansion_in(external_expansion_enable),
        .hw_stby_in(hw_stby),
        .dir_in(pin_direction[gi]),
        .data_in(pin_output_data[gi]),
        .addr_in(address_source[gi]),
        .pwm_en_in(pwm_channel_enable_in[gi]),
        .pwm_in(pwm_channel_outputs_in[gi]),
        .pullup_in(pin_pullup_control[gi]),
        .level_out(next_level[gi]),
        .drive_out(next_drive[gi]),
        .pullup_out(next_pullup[gi])
      );
    end
  endgenerate

  // Pin levels registered, so the pads never see the mux settle
  // and every pin output comes straight from a flip-flop
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_out <= `PMX_RESET_VALUE;
    end else begin
      pin_out <= next_level;
    end
  end

  // Output enables registered; every pin floats while in reset, which is
  // also the only safe state before the mode straps have settled
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_oe_out <= `PMX_RESET_VALUE;
    end else begin
      pin_oe_out <= next_drive;
    end
  end

  // Pull-ups registered; forced off while in reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pullup_on_out <= `PMX_RESET_VALUE;
    end else begin
      pullup_on_out <= next_pullup;
    end
  end

  // Read mux; direction reads as zero since its value is undefined.
  // Reading back zero rather than the register keeps software from
  // leaning on a value the port does not promise.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_hit = 1'b1;
    case (reg_index)
      `PMX_IDX_DIRECTION: next_rdata = 32'h0000_0000;
      `PMX_IDX_OUTPUT_DATA: next_rdata[PORT_W-1:0] = port_read_value;
      `PMX_IDX_PULLUP: next_rdata[PORT_W-1:0] = pin_pullup_control;
      `PMX_IDX_CONTROL: begin
        next_rdata[`PMX_CTL_MODE_MSB:`PMX_CTL_MODE_LSB] = mode_in;
        next_rdata[`PMX_CTL_EXP_BIT] = external_expansion_enable;
      end
      `PMX_IDX_STATUS: next_rdata[PORT_W-1:0] = pin_oe_out;
      default: next_hit = 1'b0;
    endcase
  end

  // One wait state: answer the cycle after the request appears.
  // The ack term in bus_req makes ack a single-cycle pulse.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= bus_req & next_hit;
    end
  end

  // Error for an unmapped index, with the same timing as ack; nothing
  // is written on such a cycle since no write strobe decodes it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_err_out <= 1'b0;
    end else begin
      wb_err_out <= bus_req & ~next_hit;
    end
  end

  // Read data stands with ack only and is zero otherwise, so a master
  // that samples late sees zero rather than stale data
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_dat_out <= (bus_req & ~wb_we_in & next_hit) ? next_rdata : 32'h0000_0000;
    end
  end

endmodule

/* pmx_pin_partner.sv */
/*
  Board side of the port pins: outside drivers, pull-ups, floating nets.
  Assumes the port drives only where its output enable is high.
*/
`timescale 1ns/1ps
module pmx_pin_partner (
  input wire logic clk_in, // System clock
  input wire logic [7:0] pin_out_in, // Port drive levels
  input wire logic [7:0] pin_oe_in, // Port output enables
  input wire logic [7:0] pullup_in, // Port pull-ups
  input wire logic [7:0] ext_en_in, // Board drives these pins
  input wire logic [7:0] ext_level_in, // Board drive levels
  output logic [7:0] level_out // Resolved pin levels
);
  logic [7:0] float_q = 8'h00;
  // An undriven net wanders, so it toggles rather than keep a stale level
  always_ff @(posedge clk_in) float_q <= ~float_q;
  // Port drive first, then the board, then the pull-up
  assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_en_in & ext_level_in) |
    (~pin_oe_in & ~ext_en_in & (pullup_in | float_q));
endmodule

/* pmx_port_properties.sv */
/*
  Checker for the port: bus handshake, pin muxing and pull-ups.
  Assumes it is bound to pmx_port and sees only its ports.
*/
`timescale 1ns/1ps
`include "pmx_map.svh"
module pmx_port_properties #(
  parameter int PORT_W = 8
) (
  input wire logic clk_in, // Clock
  input wire logic arst_n_in, // Reset, active low
  input wire logic wb_cyc_in, // Cycle
  input wire logic wb_stb_in, // Strobe
  input wire logic [`PMX_ADDR_W-1:0] wb_adr_in, // Byte address
  input wire logic wb_ack_out, // Acknowledge
  input wire logic wb_err_out, // Error
  input wire logic [1:0] mode_in, // Mode
  input wire logic [1:0] power_state_in, // Power state
  input wire logic [PORT_W-1:0] address_low_in, // Address byte
  input wire logic [PORT_W-1:0] pwm_channel_enable_in, // PWM enables
  input wire logic [PORT_W-1:0] pwm_channel_outputs_in, // PWM levels
  input wire logic [PORT_W-1:0] pin_out, // Pin levels
  input wire logic [PORT_W-1:0] pin_oe_out, // Pin enables
  input wire logic [PORT_W-1:0] pullup_on_out // Pull-ups
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic req;
  logic mapped;
  logic up;
  // Outputs lag one cycle, so pin checks wait one edge past reset
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in) up <= 1'b0;
    else up <= 1'b1;
  // Own index decode, kept apart from the design's
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  assign mapped = wb_adr_in[17:2] inside {16'hffac, 16'hffb0, 16'hffb2, 16'hffb8, 16'hffb9};
  property p_answer; req |=> wb_ack_out ^ wb_err_out; endproperty
  a_answer: assert property (p_answer) else $error("request not answered in one cycle");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_err_unmapped; req && !mapped |=> wb_err_out && !wb_ack_out; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_mode1_addr;
    up && mode_in == pmx_pkg::PMX_MODE_ONE && power_state_in == pmx_pkg::PMX_PWR_RUN
      |=> pin_oe_out == '1 && pin_out == $past(address_low_in);
  endproperty
  a_mode1_addr: assert property (p_mode1_addr) else $error("mode 1 pins not address");
  property p_hw_off;
    (up && power_state_in == pmx_pkg::PMX_PWR_HW_STBY) [*2]
      |=> pin_oe_out == '0 && pullup_on_out == '0;
  endproperty
  a_hw_off: assert property (p_hw_off) else $error("drivers on in hardware standby");
  property p_mode1_pu; up && mode_in == pmx_pkg::PMX_MODE_ONE |=> pullup_on_out == '0; endproperty
  a_mode1_pu: assert property (p_mode1_pu) else $error("pull-up on in mode 1");
  property p_pu_excl; (pullup_on_out & pin_oe_out) == '0; endproperty
  a_pu_excl: assert property (p_pu_excl) else $error("pull-up on a driven pin");
  property p_sw_freeze;
    (up && mode_in == pmx_pkg::PMX_MODE_ONE && power_state_in == pmx_pkg::PMX_PWR_SW_STBY) [*2]
      |=> $stable(pin_out) && pin_oe_out == '1;
  endproperty
  a_sw_freeze: assert property (p_sw_freeze) else $error("address moved in standby");
  property p_pwm_win;
    up && mode_in != pmx_pkg::PMX_MODE_ONE && power_state_in == pmx_pkg::PMX_PWR_RUN
      |=> ((pin_out ^ $past(pwm_channel_outputs_in)) & pin_oe_out &
        $past(pwm_channel_enable_in)) == '0;
  endproperty
  a_pwm_win: assert property (p_pwm_win) else $error("enabled PWM not on output pin");
  c_err: cover property (req && !mapped);
  c_mode1: cover property (up && mode_in == pmx_pkg::PMX_MODE_ONE);
  c_pullup: cover property (pullup_on_out != '0);
endmodule
bind pmx_port pmx_port_properties #(.PORT_W(PORT_W)) u_pmx_port_properties (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_adr_in(wb_adr_in),
  .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out), .mode_in(mode_in),
  .power_state_in(power_state_in), .address_low_in(address_low_in),
  .pwm_channel_enable_in(pwm_channel_enable_in), .pwm_channel_outputs_in(pwm_channel_outputs_in),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pullup_on_out(pullup_on_out));

/* port_one_io_address_pwm_mux_tb.sv */
/*
  Self-checking bench for the port: registers over Wishbone, pin muxing.
  Assumes the board model resolves pin levels and the checker is bound.
*/
`timescale 1ns/1ps
module port_one_io_address_pwm_mux_tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, err, er;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  logic [1:0] mode = pmx_pkg::PMX_MODE_TWO, pwr = pmx_pkg::PMX_PWR_RUN;
  logic [7:0] addr_lo = 8'h00, pwm_en = 8'h00, pwm_lv = 8'h00, ext_en = 8'hff, ext_lv = 8'h00;
  logic [7:0] lvl, pin_o, pin_oe, pu;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 clk_in = ~clk_in;
  pmx_port u_pmx_port (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
    .wb_ack_out(ack), .wb_err_out(err), .mode_in(mode), .power_state_in(pwr),
    .address_low_in(addr_lo), .pwm_channel_enable_in(pwm_en), .pwm_channel_outputs_in(pwm_lv),
    .pin_in(lvl), .pin_out(pin_o), .pin_oe_out(pin_oe), .pullup_on_out(pu));
  pmx_pin_partner u_pmx_pin_partner (.clk_in(clk_in), .pin_out_in(pin_o), .pin_oe_in(pin_oe),
    .pullup_in(pu), .ext_en_in(ext_en), .ext_level_in(ext_lv), .level_out(lvl));
  task end_sim;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; a hung slave is caught by the cycle ceiling
  task wb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    dat_w <= {24'h0, wd};
    do @(posedge clk_in); while (ack !== 1'b1 && err !== 1'b1);
    rd = dat_r;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_in);
  endtask
  // Pins are looked at mid-cycle, well after the registered update
  task pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu_e);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    check8(pin_oe, oe);
    check8(pin_o & oe, out);
    check8(pu, pu_e);
    @(posedge clk_in);
  endtask
  task t_reset;
    wb(0, 16'hffb9, 8'h00);
    check8(rd[7:0], 8'h00);
    wb(1, 16'hffb0, 8'hff);
    wb(0, 16'hffb2, 8'h00);
    check8(rd[7:0], 8'h00);
    wb(0, 16'hffac, 8'h00);
    check8(rd[7:0], 8'h00);
    wb(0, 16'hffa0, 8'h00);
    check8({7'h0, er}, 8'h01);
  endtask
  task t_single;
    ext_en <= 8'h0f;
    ext_lv <= 8'h0c;
    pwm_en <= 8'h30;
    pwm_lv <= 8'h10;
    wb(1, 16'hffb0, 8'hf0);
    wb(1, 16'hffb2, 8'ha5);
    wb(1, 16'hffac, 8'hff);
    pins(8'hf0, 8'h90, 8'h0f);
    wb(0, 16'hffb9, 8'h00);
    check8(rd[7:0], 8'hf0);
    wb(0, 16'hffb2, 8'h00);
    check8(rd[7:0], 8'hac);
    wb(0, 16'hffb0, 8'h00);
    check8(rd[7:0], 8'h00);
  endtask
  task t_exp;
    addr_lo <= 8'h5a;
    wb(1, 16'hffb8, 8'h04);
    pins(8'hf0, 8'h50, 8'h0f);
    wb(0, 16'hffb8, 8'h00);
    check8(rd[7:0], 8'h06);
  endtask
  task t_mode1;
    ext_en <= 8'h00;
    pwm_en <= 8'hff;
    mode <= pmx_pkg::PMX_MODE_ONE;
    pins(8'hff, 8'h5a, 8'h00);
  endtask
  task t_sw;
    pwr <= pmx_pkg::PMX_PWR_SW_STBY;
    @(posedge clk_in);
    addr_lo <= 8'hc3;
    pins(8'hff, 8'h5a, 8'h00);
    pwr <= pmx_pkg::PMX_PWR_RUN;
    mode <= pmx_pkg::PMX_MODE_TWO;
    pwm_en <= 8'h00;
    ext_en <= 8'h0f;
    pins(8'hf0, 8'hc0, 8'h0f);
    wb(0, 16'hffb2, 8'h00);
    check8(rd[7:0], 8'hac);
  endtask
  task t_hw;
    mode <= pmx_pkg::PMX_MODE_ONE;
    pwr <= pmx_pkg::PMX_PWR_HW_STBY;
    ext_en <= 8'hff;
    ext_lv <= 8'h3c;
    pins(8'h00, 8'h00, 8'h00);
    pwr <= pmx_pkg::PMX_PWR_RUN;
    mode <= pmx_pkg::PMX_MODE_TWO;
    pins(8'h00, 8'h00, 8'h00);
    wb(0, 16'hffac, 8'h00);
    check8(rd[7:0], 8'h00);
    ext_en <= 8'h00;
    wb(1, 16'hffb0, 8'hff);
    wb(0, 16'hffb2, 8'h00);
    check8(rd[7:0], 8'h00);
    pins(8'hff, 8'h00, 8'h00);
  endtask
  // Ceiling well above the hundred or so cycles the sequence needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_single;
    t_exp;
    t_mode1;
    t_sw;
    t_hw;
    end_sim;
  end
endmodule
